// file: hw/chip_reset_ctrl.sv
// chip reset combiner, wake timer and two-stage supply droop handling
// assumes droop, oscillator and flash inputs are synchronous to clk;
// reset request inputs may be asynchronous
`timescale 1ns/100ps
`include "reset_ctrl_defines.svh"
module chip_reset_ctrl
   import reset_ctrl_pkg::*;
#(
   parameter int WAKE_CYCLES = `WAKE_CYCLES_DEFAULT,
   parameter int CNT_W       = `WAKE_CNT_W
) (
   // clock and block reset
   input  wire logic                     clk,
   input  wire logic                     resetn,
   // reset sources
   input  wire logic                     ext_reset_n,
   input  wire logic                     watchdog_reset,
   input  wire logic                     power_on_detect,
   input  wire logic                     droop_stage2,
   // start-up conditions
   input  wire logic                     osc_running,
   input  wire logic                     flash_init_done,
   // supply droop first stage
   input  wire logic                     droop_stage1,
   // chip reset and processor start
   output logic                          chip_reset_n,
   output logic                          cpu_fetch_start,
   output logic [`FETCH_ADDR_W-1:0]      cpu_fetch_addr,
   // toward the interrupt unit and status read
   output logic                          droop_irq,
   output logic                          droop_status
);

   // =====================================================
   // source combination
   reset_src_s src;
   logic       src_any;
   logic       src_released;

   // any single source requests chip reset
   assign src.pin_req      = ~ext_reset_n;
   assign src.watchdog_req = watchdog_reset;
   assign src.power_on_req = power_on_detect;
   assign src.droop_req    = droop_stage2;
   assign src_any          = |src;

   // release of the combined request, brought onto clk
   release_sync #(
      .STAGES    (`RELEASE_SYNC_STAGES)
   ) u_release_sync (
      .clk       (clk),
      .clr_async (src_any),
      .released  (src_released)
   );

   // =====================================================
   // wake-up sequencer
   seq_state_e       state_reg;
   seq_state_e       state_next;
   logic [CNT_W-1:0] wake_cnt_reg;
   logic [CNT_W-1:0] wake_cnt_next;
   logic             count_done;
   logic             release_ok;

   localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES);

   // all four start-up conditions together
   assign count_done = (wake_cnt_reg >= WAKE_LAST);
   assign release_ok = count_done & osc_running & flash_init_done
                       & ext_reset_n;

   // next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD:  if (src_released) state_next = ST_COUNT;
         ST_COUNT: if (release_ok) state_next = ST_RUN;
         ST_RUN:   state_next = ST_RUN;
         default:  state_next = ST_HOLD;
      endcase
   end

   // timer counts only with a running oscillator and saturates
   assign wake_cnt_next = (state_reg == ST_COUNT && osc_running && !count_done)
                          ? wake_cnt_reg + CNT_W'(1) : wake_cnt_reg;

   // state and timer cleared at once by any request
   always_ff @(posedge clk or posedge src_any)
   begin
      if (src_any)
      begin
         state_reg    <= ST_HOLD;
         wake_cnt_reg <= '0;
      end
      else if (!resetn)
      begin
         state_reg    <= ST_HOLD;
         wake_cnt_reg <= '0;
      end
      else
      begin
         state_reg    <= state_next;
         wake_cnt_reg <= wake_cnt_next;
      end
   end

   // =====================================================
   // chip reset output and processor start
   logic run_next;
   logic start_next;

   assign run_next   = (state_next == ST_RUN);
   assign start_next = (state_reg == ST_COUNT) && release_ok;

   // reset output falls asynchronously, rises on clk
   always_ff @(posedge clk or posedge src_any)
   begin
      if (src_any)
         chip_reset_n <= 1'b0;
      else if (!resetn)
         chip_reset_n <= 1'b0;
      else
         chip_reset_n <= run_next;
   end

   // fetch pulse and vector at release
   always_ff @(posedge clk or posedge src_any)
   begin
      if (src_any)
      begin
         cpu_fetch_start <= 1'b0;
         cpu_fetch_addr  <= `RESET_VECTOR_ADDR;
      end
      else if (!resetn)
      begin
         cpu_fetch_start <= 1'b0;
         cpu_fetch_addr  <= `RESET_VECTOR_ADDR;
      end
      else
      begin
         cpu_fetch_start <= start_next;
         cpu_fetch_addr  <= `RESET_VECTOR_ADDR;
      end
   end

   // =====================================================
   // droop first stage: level request and status
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         droop_irq    <= 1'b0;
         droop_status <= 1'b0;
      end
      else
      begin
         droop_irq    <= droop_stage1;
         droop_status <= droop_stage1;
      end
   end

   // =====================================================
   // checks
   logic [CNT_W-1:0] held_cnt_reg;

   // cycles spent in wake counting since last release of the request
   always_ff @(posedge clk or posedge src_any)
   begin
      if (src_any)
         held_cnt_reg <= '0;
      else if (!resetn)
         held_cnt_reg <= '0;
      else if (state_reg == ST_COUNT && osc_running && held_cnt_reg != '1)
         held_cnt_reg <= held_cnt_reg + CNT_W'(1);
   end

   property p_any_source_resets;
      @(posedge clk) disable iff (!resetn)
      src_any |-> !chip_reset_n;
   endproperty
   a_any_source_resets: assert property (p_any_source_resets)
      else $error("chip reset not low while a source requests it");

   property p_release_conditions;
      @(posedge clk) disable iff (!resetn)
      $rose(chip_reset_n) |-> $past(osc_running) && $past(flash_init_done)
                              && $past(ext_reset_n);
   endproperty
   a_release_conditions: assert property (p_release_conditions)
      else $error("chip reset released without start-up conditions");

   property p_fetch_at_release;
      @(posedge clk) disable iff (!resetn)
      $rose(chip_reset_n) |-> cpu_fetch_start && cpu_fetch_addr == 32'h0000_0000
                              ##1 !cpu_fetch_start;
   endproperty
   a_fetch_at_release: assert property (p_fetch_at_release)
      else $error("fetch start not a single pulse at address zero on release");

   property p_no_fetch_in_reset;
      @(posedge clk) disable iff (!resetn)
      !chip_reset_n && !$rose(chip_reset_n) |-> !cpu_fetch_start;
   endproperty
   a_no_fetch_in_reset: assert property (p_no_fetch_in_reset)
      else $error("fetch started while chip reset held");

   property p_droop_irq_follows;
      @(posedge clk) disable iff (!resetn)
      droop_stage1 ##1 1'b1 |-> droop_irq && droop_status;
   endproperty
   a_droop_irq_follows: assert property (p_droop_irq_follows)
      else $error("droop request missing one cycle after first stage");

   property p_droop_irq_clears;
      @(posedge clk) disable iff (!resetn)
      $fell(droop_stage1) |=> !droop_irq && !droop_status;
   endproperty
   a_droop_irq_clears: assert property (p_droop_irq_clears)
      else $error("droop request stuck after first stage cleared");

   property p_stage2_holds;
      @(posedge clk) disable iff (!resetn)
      droop_stage2 ##1 droop_stage2 |-> !chip_reset_n;
   endproperty
   a_stage2_holds: assert property (p_stage2_holds)
      else $error("second droop stage did not hold chip reset");

   property p_handover_low;
      @(posedge clk) disable iff (!resetn)
      (droop_stage2 || power_on_detect) [*3] |-> !chip_reset_n [*3];
   endproperty
   a_handover_low: assert property (p_handover_low)
      else $error("chip reset rose during droop to power-on handover");

   property p_sync_release;
      @(posedge clk) disable iff (!resetn)
      $fell(src_any) |-> !chip_reset_n [*3];
   endproperty
   a_sync_release: assert property (p_sync_release)
      else $error("chip reset released before synchronised release");

   property p_wake_count;
      @(posedge clk) disable iff (!resetn)
      $rose(chip_reset_n) |-> $past(held_cnt_reg) >= WAKE_LAST;
   endproperty
   a_wake_count: assert property (p_wake_count)
      else $error("chip reset released before the wake count elapsed");

endmodule

// file: hw/release_sync.sv
// release synchroniser: clears at once, releases after STAGES clocks
// assumes clr_async is a level that may change at any time
`timescale 1ns/100ps
module release_sync #(
   parameter int STAGES = 2
) (
   // clock and asynchronous clear
   input  wire logic clk,
   input  wire logic clr_async,
   // synchronised release, high when clear has gone away
   output logic      released
);

   logic [STAGES-1:0] chain_reg;

   // shift ones in, cleared immediately by the request
   always_ff @(posedge clk or posedge clr_async)
   begin
      if (clr_async)
         chain_reg <= '0;
      else
         chain_reg <= {chain_reg[STAGES-2:0], 1'b1};
   end

   assign released = chain_reg[STAGES-1];

endmodule

// file: inc/reset_ctrl_defines.svh
// constants of the chip reset and supply droop controller
// assumes one system clock; included by its bare name
// Behaviour
// - any of pin, watchdog, power-on or droop second stage asserts chip reset
// - reset starts wake timer; release needs pin free, oscillator, count, flash done
// - on release the processor starts fetching at address zero
// - registers hold reset values by the time reset is released, except droop_irq and droop_status, which only resetn clears
// - droop first stage raises an interrupt request toward the interrupt unit
// - first stage interrupt is gated outside; also readable as a status level
// - droop second stage asserts chip reset, blocking flash alteration
// - droop and power-on detectors together hold reset with no gap
`ifndef RESET_CTRL_DEFINES_SVH
`define RESET_CTRL_DEFINES_SVH

// =====================================================
// timing
`define WAKE_CYCLES_DEFAULT 16
`define WAKE_CNT_W          16
`define RELEASE_SYNC_STAGES 2

// =====================================================
// values
`define RESET_VECTOR_ADDR   32'h0000_0000
`define FETCH_ADDR_W        32

`endif

// file: inc/reset_ctrl_pkg.sv
// types of the chip reset and supply droop controller
// assumes reset_ctrl_defines.svh for numeric constants
package reset_ctrl_pkg;

   // =====================================================
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_HOLD  = 3'b001,
      ST_COUNT = 3'b010,
      ST_RUN   = 3'b100
   } seq_state_e;

   // =====================================================
   // reset requests, all active high
   typedef struct packed {
      logic pin_req;
      logic watchdog_req;
      logic power_on_req;
      logic droop_req;
   } reset_src_s;

endpackage

// file: verification/chip_reset_ctrl_test.sv
// bench for the chip reset controller with a supply partner model
// assumes a short wake count so the run stays small
`timescale 1ns/100ps
module chip_reset_ctrl_test;
   import reset_ctrl_pkg::*;
   localparam int W = 4;
   // =====================================================
   // stimulus and observed signals
   logic        clk, resetn, ext_reset_n, watchdog_reset, osc_running, flash_init_done;
   logic        droop_stage1, droop_stage2, power_on_detect, irq_enable, cpu_irq;
   logic        chip_reset_n, cpu_fetch_start, droop_irq, droop_status;
   logic [31:0] cpu_fetch_addr;
   logic [15:0] supply_mv;
   int          miscompares, num_checks, cycles, n, prev;

   chip_reset_ctrl #(.WAKE_CYCLES(W), .CNT_W(16)) dut (
      .clk(clk), .resetn(resetn), .ext_reset_n(ext_reset_n),
      .watchdog_reset(watchdog_reset), .power_on_detect(power_on_detect),
      .droop_stage2(droop_stage2), .osc_running(osc_running),
      .flash_init_done(flash_init_done), .droop_stage1(droop_stage1),
      .chip_reset_n(chip_reset_n), .cpu_fetch_start(cpu_fetch_start),
      .cpu_fetch_addr(cpu_fetch_addr), .droop_irq(droop_irq), .droop_status(droop_status));

   supply_partner partner (
      .supply_mv(supply_mv), .irq_enable(irq_enable), .droop_irq(droop_irq),
      .droop_stage1(droop_stage1), .droop_stage2(droop_stage2),
      .power_on_detect(power_on_detect), .cpu_irq(cpu_irq));

   // =====================================================
   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 4000)
      begin
         miscompares++;
         complete_run();
      end
   end

   // =====================================================
   // shared tasks
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (exp !== got)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // counts edges to release, then checks the start pulse and address
   task automatic wait_release(int lo, int hi);
      n = 0;
      while (chip_reset_n !== 1'b1 && n <= hi)
      begin
         tick();
         n++;
      end
      check("release cycles in window", 1, n >= lo && n <= hi);
      check("fetch start", 1, cpu_fetch_start);
      check("fetch addr", 32'h0000_0000, cpu_fetch_addr);
      tick();
      check("fetch start one cycle", 0, cpu_fetch_start);
      check("droop irq cleared", 0, droop_irq);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // =====================================================
   // main sequence
   initial
   begin
      {resetn, watchdog_reset, irq_enable} = 3'h0;
      {ext_reset_n, osc_running, flash_init_done} = 3'h7;
      supply_mv = 16'd3300;
      {miscompares, num_checks, cycles} = 0;
      void'($urandom(96790));
      repeat (12) @(posedge clk);
      #1;
      check("reset during block reset", 0, chip_reset_n);
      resetn = 1'b1;
      wait_release(0, W + 10);
      // pin, watchdog, droop second stage, then power-on with second stage; assertion needs no clock edge
      for (int s = 0; s < 4; s++)
      begin
         repeat ($urandom_range(1, 3)) tick();
         case (s)
            0: ext_reset_n = 1'b0;
            1: watchdog_reset = 1'b1;
            2: supply_mv = 16'd1500;
            default: supply_mv = 16'd800;
         endcase
         #1;
         check("async assert", 0, chip_reset_n);
         tick();
         {ext_reset_n, watchdog_reset} = 2'b10;
         supply_mv = 16'd3300;
         wait_release(W, W + 8);
      end
      // a second request part way through the count restarts it
      watchdog_reset = 1'b1;
      tick();
      watchdog_reset = 1'b0;
      repeat (W) tick();
      watchdog_reset = 1'b1;
      tick();
      watchdog_reset = 1'b0;
      wait_release(W, W + 8);
      // oscillator, then flash, then the pin holding reset
      for (int g = 0; g < 3; g++)
      begin
         watchdog_reset = 1'b1;
         osc_running = g != 0;
         flash_init_done = g != 1;
         tick();
         watchdog_reset = 1'b0;
         if (g == 2)
            ext_reset_n = 1'b0;
         repeat (3 * W) tick();
         check("held by start-up condition", 0, chip_reset_n);
         {ext_reset_n, osc_running, flash_init_done} = 3'h7;
         wait_release(0, W + 8);
      end
      // first stage against a one-cycle delayed model, random enable
      prev = 0;
      for (int i = 0; i < 40; i++)
      begin
         supply_mv = 16'($urandom_range(2000, 2400));
         irq_enable = 1'($urandom_range(0, 1));
         prev = supply_mv < 16'd2200;
         tick();
         check("droop irq", prev, droop_irq);
         check("droop status", prev, droop_status);
         check("gated irq", prev & irq_enable, cpu_irq);
         check("no reset from stage one", 1, chip_reset_n);
      end
      // block reset mid-run clears chip reset and the droop request
      supply_mv = 16'd2100;
      resetn = 1'b0;
      tick();
      check("chip reset in block reset", 0, chip_reset_n);
      check("droop irq in block reset", 0, droop_irq);
      resetn = 1'b1;
      supply_mv = 16'd3300;
      wait_release(W, W + 8);
      // supply sweep down to zero and back up to 1800 mV, still held
      for (int v = 3300; v > -1900; v -= 150)
      begin
         supply_mv = 16'(v < 0 ? -v : v);
         tick();
         if (supply_mv < 1850)
            check("reset under droop", 0, chip_reset_n);
      end
      supply_mv = 16'd3300;
      wait_release(W, W + 8);
      complete_run();
   end
endmodule

// file: verification/supply_partner.sv
// far side model: supply comparators on a level in mV, interrupt enable gate
// assumes the bench steps supply_mv shortly after a clock edge
`timescale 1ns/100ps
module supply_partner #(
   parameter int STAGE1_MV = 2200,
   parameter int STAGE2_MV = 1850,
   parameter int POR_MV    = 1000
) (
   // supply level and enable in the interrupt unit
   input  wire logic [15:0] supply_mv,
   input  wire logic        irq_enable,
   input  wire logic        droop_irq,
   // comparator outputs
   output logic             droop_stage1,
   output logic             droop_stage2,
   output logic             power_on_detect,
   // gated processor interrupt
   output logic             cpu_irq
);
   // =====================================================
   // comparators; stage two stays set below the power-on level, so no gap
   assign droop_stage1    = supply_mv < STAGE1_MV;
   assign droop_stage2    = supply_mv < STAGE2_MV;
   assign power_on_detect = supply_mv < POR_MV;
   // interrupt reaches the processor only while enabled
   assign cpu_irq         = droop_irq & irq_enable;
endmodule
